// [core/tct_pkg.sv]
// Functional notes
// - translated write: processor code becomes tape code before recording
// - translated read: tape code becomes processor code before delivery
// - auxiliary unit maps six data bits of each read frame to processor code when the translate bit is set
// - auxiliary unit has no write table; write functions are refused there
// - bits 17-9 octal: function digit, parity digit, gain digit
package tct_pkg;
    localparam int unsigned ADDR_W    = 4;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned FUNC_W    = 18;
    localparam int unsigned CHAR_W    = 6;
    localparam int unsigned CNT_W     = 16;

    localparam logic [3:0] OFS_FUNC   = 4'h0;
    localparam logic [3:0] OFS_STAT   = 4'h4;
    localparam logic [3:0] OFS_COUNT  = 4'h8;

    // function word field positions
    localparam int unsigned FN_OP_HI  = 17;
    localparam int unsigned FN_OP_LO  = 15;
    localparam int unsigned FN_PAR    = 14;
    localparam int unsigned FN_DEN_HI = 13;
    localparam int unsigned FN_DEN_LO = 12;
    localparam int unsigned FN_XLAT   = 11;
    localparam int unsigned FN_GAIN   = 9;

    localparam logic [2:0] OP_READ_FWD  = 3'h6;
    localparam logic [2:0] OP_READ_BWD  = 3'h1;
    localparam logic [2:0] OP_WRITE     = 3'h5;
    localparam logic [2:0] OP_SKIP_WR   = 3'h7;

    localparam logic [FUNC_W-1:0] FUNC_RST = 18'h00000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_READ  = 3'h2,
        ST_WRITE = 3'h4
    } tct_state_t;

    typedef logic [CHAR_W-1:0] tct_tbl_t [64];

    // tape code -> processor code, read direction
    localparam tct_tbl_t READ_TBL = '{
        6'h26, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37,
        6'h38, 6'h39, 6'h30, 6'h24, 6'h3a, 6'h2b, 6'h25, 6'h00,
        6'h05, 6'h3c, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d,
        6'h1e, 6'h1f, 6'h3f, 6'h2e, 6'h29, 6'h2a, 6'h2f, 6'h00,
        6'h21, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15,
        6'h16, 6'h17, 6'h2d, 6'h27, 6'h28, 6'h02, 6'h3b, 6'h04,
        6'h22, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c,
        6'h0d, 6'h0e, 6'h2c, 6'h3d, 6'h20, 6'h01, 6'h23, 6'h03
    };

    // processor code -> tape code, write direction
    localparam tct_tbl_t WRITE_TBL = '{
        6'h0f, 6'h3d, 6'h2d, 6'h3f, 6'h2f, 6'h10, 6'h31, 6'h32,
        6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h21,
        6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29,
        6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
        6'h3c, 6'h20, 6'h30, 6'h3e, 6'h0b, 6'h0e, 6'h00, 6'h2b,
        6'h2c, 6'h1c, 6'h1d, 6'h0d, 6'h3a, 6'h2a, 6'h1b, 6'h1e,
        6'h0a, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
        6'h08, 6'h09, 6'h0c, 6'h2e, 6'h11, 6'h3b, 6'h00, 6'h1a
    };
endpackage

// [core/tct_translator.sv]
`timescale 1ns/1ns
module tct_translator #(
    parameter bit AUX_UNIT = 1'b0
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_n,
    input  wire logic [tct_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [tct_pkg::DATA_W-1:0]   i_wr_data,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [tct_pkg::DATA_W-1:0]   o_rd_data,
    input  wire logic                         i_char_valid,
    input  wire logic [tct_pkg::CHAR_W-1:0]   i_char,
    output logic                              o_char_valid,
    output logic      [tct_pkg::CHAR_W-1:0]   o_char
);
    typedef struct packed {
        tct_pkg::tct_state_t              state;
        logic [tct_pkg::FUNC_W-1:0]       func;
        logic                             xlat;
        logic                             refused;
        logic [tct_pkg::CNT_W-1:0]        count;
        logic                             char_valid;
        logic [tct_pkg::CHAR_W-1:0]       char_out;
        logic [tct_pkg::DATA_W-1:0]       rd_data;
    } tct_regs_t;

    tct_regs_t r;
    tct_regs_t next_r;
    logic [2:0] op;
    logic [tct_pkg::CHAR_W-1:0] mapped;

    always_comb begin
        next_r = r;
        next_r.char_valid = 1'b0;
        next_r.rd_data = '0;
        op = i_wr_data[tct_pkg::FN_OP_HI:tct_pkg::FN_OP_LO];
        mapped = i_char;

        if (i_wr && i_addr == tct_pkg::OFS_FUNC) begin
            next_r.func = i_wr_data[tct_pkg::FUNC_W-1:0];
            next_r.xlat = i_wr_data[tct_pkg::FN_XLAT];
            next_r.count = '0;
            next_r.refused = 1'b0;
            // leading octal digit picks the function
            if (op == tct_pkg::OP_READ_FWD || op == tct_pkg::OP_READ_BWD) begin
                next_r.state = tct_pkg::ST_READ;
            end else if (op == tct_pkg::OP_WRITE
                         || op == tct_pkg::OP_SKIP_WR) begin
                if (AUX_UNIT) begin
                    // no processor-to-tape path in the auxiliary unit
                    next_r.state = tct_pkg::ST_IDLE;
                    next_r.refused = 1'b1;
                end else begin
                    next_r.state = tct_pkg::ST_WRITE;
                end
            end else begin
                next_r.state = tct_pkg::ST_IDLE;
                next_r.refused = (op != 3'h0);
            end
        end else if (i_char_valid) begin
            unique case (r.state)
                tct_pkg::ST_READ: begin
                    if (r.xlat) begin
                        mapped = tct_pkg::READ_TBL[i_char];
                    end
                    next_r.char_valid = 1'b1;
                    next_r.char_out = mapped;
                    next_r.count = r.count + 1'b1;
                end
                tct_pkg::ST_WRITE: begin
                    if (r.xlat) begin
                        mapped = tct_pkg::WRITE_TBL[i_char];
                    end
                    next_r.char_valid = 1'b1;
                    next_r.char_out = mapped;
                    next_r.count = r.count + 1'b1;
                end
                tct_pkg::ST_IDLE: begin
                    next_r.char_valid = 1'b0;
                end
                default: begin
                    next_r.state = tct_pkg::ST_IDLE;
                end
            endcase
        end

        if (i_rd) begin
            unique case (i_addr)
                tct_pkg::OFS_FUNC: begin
                    next_r.rd_data = {14'h0000, r.func};
                end
                tct_pkg::OFS_STAT: begin
                    next_r.rd_data = {
                        24'h000000,
                        r.func[tct_pkg::FN_GAIN],
                        r.func[tct_pkg::FN_DEN_HI:tct_pkg::FN_DEN_LO],
                        r.func[tct_pkg::FN_PAR],
                        r.refused,
                        r.xlat,
                        (r.state == tct_pkg::ST_WRITE),
                        (r.state == tct_pkg::ST_READ)
                    };
                end
                tct_pkg::OFS_COUNT: begin
                    next_r.rd_data = {16'h0000, r.count};
                end
                default: begin
                    next_r.rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r.state      <= tct_pkg::ST_IDLE;
            r.func       <= tct_pkg::FUNC_RST;
            r.xlat       <= 1'b0;
            r.refused    <= 1'b0;
            r.count      <= '0;
            r.char_valid <= 1'b0;
            r.char_out   <= '0;
            r.rd_data    <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_rd_data    = r.rd_data;
    assign o_char_valid = r.char_valid;
    assign o_char       = r.char_out;

    // checks
    property p_write_xlat;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (r.state == tct_pkg::ST_WRITE && r.xlat && i_char_valid && !i_wr)
        |=> (o_char_valid && o_char == tct_pkg::WRITE_TBL[$past(i_char)]);
    endproperty
    a_write_xlat: assert property (p_write_xlat)
        else $error("write character not mapped to tape code");

    property p_read_xlat;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (r.state == tct_pkg::ST_READ && r.xlat && i_char_valid && !i_wr)
        |=> (o_char_valid && o_char == tct_pkg::READ_TBL[$past(i_char)]);
    endproperty
    a_read_xlat: assert property (p_read_xlat)
        else $error("read character not mapped to processor code");

    property p_aux_no_write;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        AUX_UNIT |-> (r.state != tct_pkg::ST_WRITE);
    endproperty
    a_aux_no_write: assert property (p_aux_no_write)
        else $error("auxiliary unit entered a write function");

    property p_aux_read;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (AUX_UNIT && r.state == tct_pkg::ST_READ && i_char_valid && !i_wr)
        |=> o_char_valid;
    endproperty
    a_aux_read: assert property (p_aux_read)
        else $error("auxiliary unit dropped a read frame");

    property p_decode;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == tct_pkg::OFS_FUNC
         && i_wr_data[tct_pkg::FN_OP_HI:tct_pkg::FN_OP_LO]
            == tct_pkg::OP_READ_BWD)
        |=> (r.state == tct_pkg::ST_READ
             && r.xlat == $past(i_wr_data[tct_pkg::FN_XLAT]));
    endproperty
    a_decode: assert property (p_decode)
        else $error("read backward code not decoded");

    property p_passthru;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (r.state != tct_pkg::ST_IDLE && !r.xlat && i_char_valid && !i_wr)
        |=> (o_char_valid && o_char == $past(i_char));
    endproperty
    a_passthru: assert property (p_passthru)
        else $error("untranslated character altered");

    property p_aux_refuse;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (AUX_UNIT && i_wr && i_addr == tct_pkg::OFS_FUNC
         && (op == tct_pkg::OP_WRITE || op == tct_pkg::OP_SKIP_WR))
        |=> (r.refused && r.state == tct_pkg::ST_IDLE);
    endproperty
    a_aux_refuse: assert property (p_aux_refuse)
        else $error("auxiliary unit accepted a write function");

    property p_write_decode;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!AUX_UNIT && i_wr && i_addr == tct_pkg::OFS_FUNC
         && (op == tct_pkg::OP_WRITE || op == tct_pkg::OP_SKIP_WR))
        |=> (r.state == tct_pkg::ST_WRITE && !r.refused);
    endproperty
    a_write_decode: assert property (p_write_decode)
        else $error("write code not decoded");

    property p_fwd_decode;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == tct_pkg::OFS_FUNC && op == tct_pkg::OP_READ_FWD)
        |=> (r.state == tct_pkg::ST_READ && !r.refused);
    endproperty
    a_fwd_decode: assert property (p_fwd_decode)
        else $error("read forward code not decoded");

    property p_func_xlat;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == tct_pkg::OFS_FUNC)
        |=> (r.xlat == $past(i_wr_data[tct_pkg::FN_XLAT])
             && r.count == '0);
    endproperty
    a_func_xlat: assert property (p_func_xlat)
        else $error("translate bit not taken from function word");

    property p_idle_quiet;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (r.state == tct_pkg::ST_IDLE) |=> !o_char_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("character passed with no active function");
endmodule // tct_translator

// [dv/tct_host_model.sv]
`timescale 1ns/1ns
module tct_host_model (
    input  wire logic                       i_sys_clk,
    output logic      [tct_pkg::ADDR_W-1:0] o_addr,
    output logic      [tct_pkg::DATA_W-1:0] o_wr_data,
    output logic                            o_wr,
    output logic                            o_rd,
    output logic                            o_char_valid,
    output logic      [tct_pkg::CHAR_W-1:0] o_char
);
    initial begin
        o_addr = '0;
        o_wr_data = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_char_valid = 1'b0;
        o_char = '0;
    end
    // released address and data lines go inverse so stale data never looks valid
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge i_sys_clk);
        o_wr <= wr;
        o_rd <= !wr;
        o_addr <= a;
        o_wr_data <= d;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask
    task automatic start(input logic [2:0] op, mid, fin);
        logic [2:0] g;
        g = fin;
        if (op == tct_pkg::OP_WRITE || op == tct_pkg::OP_SKIP_WR) begin
            g[0] = 1'b1;
        end
        bus(1'b1, tct_pkg::OFS_FUNC, {14'h0, op, mid, g, 9'h0});
    endtask
    task automatic chars(input logic [5:0] x);
        logic [5:0] c;
        for (int i = 0; i < 64; i++) begin
            @(posedge i_sys_clk);
            c = 6'(i) ^ x;
            o_char_valid <= 1'b1;
            o_char <= c;
        end
        @(posedge i_sys_clk);
        o_char_valid <= 1'b0;
        o_char <= ~c;
    endtask
endmodule // tct_host_model

// [dv/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic        i_sys_clk, i_rst_n, i_wr, i_rd, i_char_valid, rd_d, wr_mode;
    logic [3:0]  i_addr;
    logic [31:0] i_wr_data, o_rd_data, exp_rd[$];
    logic [31:0] aux_rd, exp_aux[$];
    logic        o_char_valid, aux_valid;
    logic [5:0]  i_char, o_char, aux_char, exp_char[$], e;
    int          fails, checks;
    tct_host_model host (.i_sys_clk(i_sys_clk), .o_addr(i_addr),
        .o_wr_data(i_wr_data), .o_wr(i_wr), .o_rd(i_rd),
        .o_char_valid(i_char_valid), .o_char(i_char));
    tct_translator dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data), .i_char_valid(i_char_valid),
        .i_char(i_char), .o_char_valid(o_char_valid), .o_char(o_char));
    tct_translator #(.AUX_UNIT(1'b1)) dut_aux (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(aux_rd),
        .i_char_valid(i_char_valid), .i_char(i_char),
        .o_char_valid(aux_valid), .o_char(aux_char));
    task automatic check(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) rd_d <= i_rd;
    // sample mid-cycle, after registered outputs have settled
    always @(negedge i_sys_clk) begin
        if (o_char_valid === 1'b1) begin
            e = exp_char.pop_front();
            check(32'(o_char), 32'(e));
            check(wr_mode ? 32'(aux_valid) : {25'h0, aux_valid, aux_char},
                  wr_mode ? 32'h0 : {25'h0, 1'b1, e});
        end
        if (rd_d === 1'b1) begin
            check(o_rd_data, exp_rd.pop_front());
            check(aux_rd, exp_aux.pop_front());
        end
    end
    task automatic run(input logic [2:0] op, mid, fin);
        logic [5:0] x, c;
        logic [31:0] st;
        logic act;
        act = op inside {3'h6, 3'h1, 3'h5, 3'h7};
        wr_mode = op inside {3'h5, 3'h7};
        host.start(op, mid, fin);
        x = 6'($urandom);
        for (int i = 0; i < 64; i++) begin
            c = 6'(i) ^ x;
            if (act) exp_char.push_back(!fin[2] ? c : wr_mode ?
                tct_pkg::WRITE_TBL[c] : tct_pkg::READ_TBL[c]);
        end
        host.chars(x);
        st = {24'h0, fin[0], mid[1:0], mid[2],
            !act && op != 3'h0, fin[2], wr_mode, act && !wr_mode};
        exp_rd.push_back(st);
        // auxiliary unit refuses writes: idle, refused flag up
        exp_aux.push_back(wr_mode ? (st & ~32'h2) | 32'h8 : st);
        host.bus(1'b0, tct_pkg::OFS_STAT, 32'h0);
        exp_rd.push_back(act ? 32'h40 : 32'h0);
        exp_aux.push_back(act && !wr_mode ? 32'h40 : 32'h0);
        host.bus(1'b0, tct_pkg::OFS_COUNT, 32'h0);
        for (int k = 0; k < 50 && exp_char.size() + exp_rd.size() > 0; k++)
            @(posedge i_sys_clk);
        if (exp_char.size() + exp_rd.size() > 0) begin
            fails++;
            $display("Error at %0t: results missing", $time);
            give_verdict();
        end
        $display("test %0o%0o%0o done", op, mid, fin);
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        i_rst_n = 1'b0;
        wr_mode = 1'b0;
        void'($urandom(32'h75ea));
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        run(3'h6, 3'h0, 3'h4);
        run(3'h1, 3'h4, 3'h5);
        run(3'h5, 3'h2, 3'h5);
        run(3'h7, 3'h7, 3'h5);
        run(3'h6, 3'h3, 3'h0);
        run(3'h5, 3'h1, 3'h1);
        run(3'h2, 3'h0, 3'h4);
        run(3'h0, 3'h0, 3'h0);
        exp_rd.push_back(32'h0);
        exp_aux.push_back(32'h0);
        host.bus(1'b0, 4'hc, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        give_verdict();
    end
endmodule // tb_top
